// ### src/flash_cmd_pkg.sv
// constants and types for the flash program/status sequencer
package flash_cmd_pkg;
    // bus widths
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    // address fields: unlock decode window, bank, sector, burst line
    localparam int UNLOCK_W = 12;
    localparam int BANK_LSB = 20;
    localparam int SECT_LSB = 15;
    localparam int LINE_W = 6;
    // unlock and command codes
    localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
    localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    // burst boundary handling
    localparam logic [2:0] BOUNDARY_WAIT = 3'h2;
    localparam logic [5:0] EXEMPT_OFS0 = 6'h3e;
    localparam logic [5:0] EXEMPT_OFS1 = 6'h3f;
    // status word bit positions
    localparam int ST_POLL = 7;
    localparam int ST_TGL = 6;
    localparam int ST_ERASE = 3;
    localparam int ST_SUSP_TGL = 2;
    // values after reset
    localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // command sequence states
    typedef enum logic [2:0] {
        CMD_IDLE = 3'b000,
        CMD_UNL1 = 3'b001,
        CMD_UNL2 = 3'b010,
        CMD_PROG = 3'b011,
        CMD_ERS0 = 3'b100,
        CMD_ERS1 = 3'b101,
        CMD_ERS2 = 3'b110
    } cmd_state_t;
endpackage

// ### src/flash_program_status_interface.sv
// flash command decoder, status reporting and synchronous burst read front end
// What this block does
// - unlock cycles decode only low address bits
// - sync program latches address on first event
// - async program accepted in any read mode
// - finished algorithm: reads return true stored data
// - toggle flag flips per status read while busy
// - async mode: ready low while algorithm runs
// - ready with data or one cycle early
// - suspend toggle flips only in suspended sector
// - output or chip enable cycling counts as read
// - 64-word boundary adds two cycles, except 3Eh/3Fh
// - other banks readable while one bank busy
// - sync status reads use normal burst timing
`timescale 1ns/1ps
module flash_program_status_interface (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // host bus strobes and address
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic address_valid_strobe_n,
    input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr,
    // data pins, split into input, output and enable
    input wire logic [flash_cmd_pkg::DATA_W-1:0] dq_in,
    output logic [flash_cmd_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic rdy,
    // read configuration
    input wire logic sync_read_mode,
    input wire logic ready_timing_select_bit,
    input wire logic [2:0] wait_states,
    // array read port
    output logic [flash_cmd_pkg::ADDR_W-1:0] array_addr,
    input wire logic [flash_cmd_pkg::DATA_W-1:0] array_rdata,
    // embedded algorithm engine
    output logic alg_start,
    output logic alg_erase,
    output logic alg_chip,
    output logic alg_suspend,
    output logic [flash_cmd_pkg::ADDR_W-1:0] program_target_address,
    output logic [flash_cmd_pkg::DATA_W-1:0] program_word,
    input wire logic alg_done
);

    typedef struct packed {
        flash_cmd_pkg::cmd_state_t cmd;
        logic armed;
        logic we_prev;
        logic oe_prev;
        logic ce_prev;
        logic avd_prev;
        logic [flash_cmd_pkg::ADDR_W-1:0] cap_addr;
        logic busy;
        logic erasing;
        logic chip;
        logic susp;
        logic start;
        logic [flash_cmd_pkg::ADDR_W-1:0] tgt_addr;
        logic [flash_cmd_pkg::DATA_W-1:0] tgt_word;
        logic operation_toggle_flag;
        logic erase_suspend_toggle_flag;
        logic burst;
        logic [2:0] wait_cnt;
        logic exempt;
        logic [flash_cmd_pkg::ADDR_W-1:0] burst_addr;
        logic [flash_cmd_pkg::DATA_W-1:0] dq;
        logic fresh;
        logic oe;
    } state_t;

    state_t st_q;
    state_t st_d;

    // edge detects on the sampled strobes
    logic we_rise;
    logic we_fall;
    logic avd_fall;
    logic new_read;
    logic wr;
    logic [flash_cmd_pkg::ADDR_W-1:0] rd_addr;
    logic rd_busy_bank;
    logic rd_susp_sector;
    logic [flash_cmd_pkg::DATA_W-1:0] status_word;
    logic [flash_cmd_pkg::DATA_W-1:0] rd_word;
    logic unl1;
    logic unl2;
    logic [7:0] wd;

    assign we_rise = we_n && !st_q.we_prev && !ce_n;
    assign we_fall = !we_n && st_q.we_prev && !ce_n;
    assign avd_fall = !address_valid_strobe_n && st_q.avd_prev && !ce_n;
    // a fresh read begins when either enable falls while the other is low
    assign new_read = (!oe_n && st_q.oe_prev && !ce_n) || (!ce_n && st_q.ce_prev && !oe_n);
    // a write counts only once chip select or strobe has gone high since the last
    assign wr = we_rise && st_q.armed;
    assign wd = dq_in[7:0];
    // only the low address bits take part in unlock matching
    assign unl1 = (st_q.cap_addr[flash_cmd_pkg::UNLOCK_W-1:0] == flash_cmd_pkg::UNLOCK_ADDR1);
    assign unl2 = (st_q.cap_addr[flash_cmd_pkg::UNLOCK_W-1:0] == flash_cmd_pkg::UNLOCK_ADDR2);

    // read address: burst pointer in sync bursts, latched address otherwise
    assign rd_addr = st_q.burst ? st_q.burst_addr : st_q.cap_addr;
    assign array_addr = rd_addr;
    assign rd_busy_bank = (st_q.busy || st_q.susp)
        && (rd_addr[flash_cmd_pkg::ADDR_W-1:flash_cmd_pkg::BANK_LSB]
        == st_q.tgt_addr[flash_cmd_pkg::ADDR_W-1:flash_cmd_pkg::BANK_LSB]);
    assign rd_susp_sector = st_q.susp
        && (rd_addr[flash_cmd_pkg::ADDR_W-1:flash_cmd_pkg::SECT_LSB]
        == st_q.tgt_addr[flash_cmd_pkg::ADDR_W-1:flash_cmd_pkg::SECT_LSB]);

    // status word: polling bit is the complement of bit 7 of the word being programmed, or the suspend flag while erasing
    always_comb
    begin
        status_word = flash_cmd_pkg::DATA_RST;
        status_word[flash_cmd_pkg::ST_POLL] = st_q.erasing ? st_q.susp
            : !st_q.tgt_word[flash_cmd_pkg::ST_POLL];
        status_word[flash_cmd_pkg::ST_TGL] = st_q.operation_toggle_flag;
        status_word[flash_cmd_pkg::ST_ERASE] = st_q.erasing && !st_q.susp;
        status_word[flash_cmd_pkg::ST_SUSP_TGL] = st_q.erase_suspend_toggle_flag;
    end

    // busy bank or suspended sector gives status, any other address gives array data
    assign rd_word = rd_busy_bank && (st_q.busy || rd_susp_sector) ? status_word
        : array_rdata;

    // next state
    always_comb
    begin
        st_d = st_q;
        st_d.we_prev = we_n;
        st_d.oe_prev = oe_n;
        st_d.ce_prev = ce_n;
        st_d.avd_prev = address_valid_strobe_n;
        st_d.start = 1'b0;
        st_d.fresh = 1'b0;
        st_d.oe = !oe_n && !ce_n && we_n;
        if (ce_n || address_valid_strobe_n)
        begin
            st_d.armed = 1'b1;
        end

        // address capture
        if (sync_read_mode)
        begin
            // only the first clock edge with strobe low captures; a strobe rise captures nothing
            if (avd_fall)
            begin
                st_d.cap_addr = addr;
            end
        end
        else if (!address_valid_strobe_n || we_fall)
        begin
            st_d.cap_addr = addr;
        end

        // command sequencer, writes taken on write-enable rise
        if (wr)
        begin
            st_d.armed = 1'b0;
            if (wd == flash_cmd_pkg::CMD_RESET)
            begin
                st_d.cmd = flash_cmd_pkg::CMD_IDLE;
            end
            else
            begin
                unique case (st_q.cmd)
                    flash_cmd_pkg::CMD_IDLE:
                    begin
                        if (unl1 && wd == flash_cmd_pkg::UNLOCK_DATA1)
                        begin
                            st_d.cmd = flash_cmd_pkg::CMD_UNL1;
                        end
                        else if (st_q.busy && st_q.erasing && wd == flash_cmd_pkg::CMD_SUSPEND)
                        begin
                            st_d.susp = 1'b1;
                            st_d.busy = 1'b0;
                        end
                        else if (st_q.susp && wd == flash_cmd_pkg::CMD_RESUME)
                        begin
                            st_d.susp = 1'b0;
                            st_d.busy = 1'b1;
                        end
                    end
                    flash_cmd_pkg::CMD_UNL1:
                    begin
                        st_d.cmd = (unl2 && wd == flash_cmd_pkg::UNLOCK_DATA2)
                            ? flash_cmd_pkg::CMD_UNL2 : flash_cmd_pkg::CMD_IDLE;
                    end
                    flash_cmd_pkg::CMD_UNL2:
                    begin
                        st_d.cmd = flash_cmd_pkg::CMD_IDLE;
                        if (unl1 && wd == flash_cmd_pkg::CMD_PROGRAM && !st_q.busy)
                        begin
                            st_d.cmd = flash_cmd_pkg::CMD_PROG;
                        end
                        else if (unl1 && wd == flash_cmd_pkg::CMD_ERASE_SETUP && !st_q.busy
                            && !st_q.susp)
                        begin
                            st_d.cmd = flash_cmd_pkg::CMD_ERS0;
                        end
                    end
                    flash_cmd_pkg::CMD_PROG:
                    begin
                        // program target and word start the algorithm
                        st_d.cmd = flash_cmd_pkg::CMD_IDLE;
                        st_d.tgt_addr = st_q.cap_addr;
                        st_d.tgt_word = dq_in;
                        st_d.busy = 1'b1;
                        st_d.erasing = 1'b0;
                        st_d.chip = 1'b0;
                        st_d.start = 1'b1;
                    end
                    flash_cmd_pkg::CMD_ERS0:
                    begin
                        st_d.cmd = (unl1 && wd == flash_cmd_pkg::UNLOCK_DATA1)
                            ? flash_cmd_pkg::CMD_ERS1 : flash_cmd_pkg::CMD_IDLE;
                    end
                    flash_cmd_pkg::CMD_ERS1:
                    begin
                        st_d.cmd = (unl2 && wd == flash_cmd_pkg::UNLOCK_DATA2)
                            ? flash_cmd_pkg::CMD_ERS2 : flash_cmd_pkg::CMD_IDLE;
                    end
                    flash_cmd_pkg::CMD_ERS2:
                    begin
                        st_d.cmd = flash_cmd_pkg::CMD_IDLE;
                        // the sector to erase is the address of this last cycle
                        if (wd == flash_cmd_pkg::CMD_SECTOR_ERASE
                            || (unl1 && wd == flash_cmd_pkg::CMD_CHIP_ERASE))
                        begin
                            st_d.tgt_addr = st_q.cap_addr;
                            st_d.tgt_word = flash_cmd_pkg::DATA_RST;
                            st_d.busy = 1'b1;
                            st_d.erasing = 1'b1;
                            st_d.chip = (wd == flash_cmd_pkg::CMD_CHIP_ERASE);
                            st_d.start = 1'b1;
                        end
                    end
                    default:
                    begin
                        st_d.cmd = flash_cmd_pkg::CMD_IDLE;
                    end
                endcase
            end
        end

        // completion ends status reporting; a new start in this cycle still wins
        if (alg_done && !st_d.start)
        begin
            st_d.busy = 1'b0;
            st_d.susp = 1'b0;
            st_d.erasing = 1'b0;
        end

        // toggle flags advance once per new status read or sync access
        if ((new_read || (sync_read_mode && avd_fall && we_n)) && rd_busy_bank)
        begin
            if (st_q.busy)
            begin
                st_d.operation_toggle_flag = !st_q.operation_toggle_flag;
            end
            if (rd_susp_sector)
            begin
                st_d.erase_suspend_toggle_flag = !st_q.erase_suspend_toggle_flag;
            end
        end

        // synchronous burst: latency, then one word per clock
        if (ce_n || !sync_read_mode)
        begin
            st_d.burst = 1'b0;
        end
        else if (avd_fall && we_n)
        begin
            st_d.burst = 1'b1;
            st_d.burst_addr = addr;
            st_d.wait_cnt = wait_states;
            st_d.exempt = (addr[flash_cmd_pkg::LINE_W-1:0] == flash_cmd_pkg::EXEMPT_OFS0)
                || (addr[flash_cmd_pkg::LINE_W-1:0] == flash_cmd_pkg::EXEMPT_OFS1);
        end
        else if (st_q.burst)
        begin
            if (st_q.wait_cnt != 3'h0)
            begin
                st_d.wait_cnt = st_q.wait_cnt - 3'h1;
            end
            else
            begin
                // status words share the same clocked path as array words
                st_d.dq = rd_word;
                st_d.fresh = 1'b1;
                st_d.burst_addr = st_q.burst_addr + 22'h000001;
                if (st_d.burst_addr[flash_cmd_pkg::LINE_W-1:0] == 6'h00 && !st_q.exempt)
                begin
                    st_d.wait_cnt = flash_cmd_pkg::BOUNDARY_WAIT;
                end
            end
        end

        // asynchronous reads follow the latched address every clock
        if (!sync_read_mode && !oe_n && !ce_n)
        begin
            st_d.dq = rd_word;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.cmd <= flash_cmd_pkg::CMD_IDLE;
            st_q.we_prev <= 1'b1;
            st_q.oe_prev <= 1'b1;
            st_q.ce_prev <= 1'b1;
            st_q.avd_prev <= 1'b1;
            st_q.armed <= 1'b1;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
        end
    end

    // outputs; ready is a handshake and may be combinational
    assign dq_out = st_q.dq;
    assign dq_oe = st_q.oe;
    always_comb
    begin
        if (!sync_read_mode)
        begin
            rdy = !st_q.busy;
        end
        else if (st_q.burst)
        begin
            // early ready warns one clock before the word lands
            rdy = ready_timing_select_bit ? (st_q.wait_cnt == 3'h0) : st_q.fresh;
        end
        else
        begin
            rdy = 1'b1;
        end
    end
    assign alg_start = st_q.start;
    assign alg_erase = st_q.erasing;
    assign alg_chip = st_q.chip;
    assign alg_suspend = st_q.susp;
    assign program_target_address = st_q.tgt_addr;
    assign program_word = st_q.tgt_word;

endmodule // flash_program_status_interface

// ### testbench/flash_host_model.sv
// host memory controller model driving the flash bus
`timescale 1ns/1ps
module flash_host_model (
    // clock
    input wire logic mclk,
    // bus strobes, address and write data
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic address_valid_strobe_n,
    output logic [flash_cmd_pkg::ADDR_W-1:0] addr,
    output logic [flash_cmd_pkg::DATA_W-1:0] dq_in,
    // returned data and ready
    input wire logic [flash_cmd_pkg::DATA_W-1:0] dq_out,
    input wire logic rdy
);
    // bus idle from time zero
    initial
    begin
        {ce_n, oe_n, we_n, address_valid_strobe_n} = 4'hf;
        addr = 22'h0;
        dq_in = 16'h0;
    end
    // every change lands a fixed delay after the edge
    task stp();
        @(posedge mclk);
        #5;
    endtask
    // released lines flip so a stale value is never mistaken for a valid one
    task idle();
        ce_n = 1'b1;
        oe_n = 1'b1;
        address_valid_strobe_n = 1'b1;
        addr = ~addr;
        dq_in = ~dq_in;
    endtask
    // one write; scr moves the address once the strobe edge has passed
    task wr(input logic [21:0] a, input logic [15:0] d, input bit scr);
        stp();
        {ce_n, address_valid_strobe_n} = 2'h0;
        addr = a;
        dq_in = d;
        stp();
        we_n = 1'b0;
        if (scr)
            addr = ~a;
        stp();
        we_n = 1'b1;
        stp();
        idle();
    endtask
    // one read; by_ce makes chip select the strobe that opens it
    task rd(input logic [21:0] a, input bit by_ce, output logic [15:0] q);
        stp();
        address_valid_strobe_n = 1'b0;
        addr = a;
        if (by_ce)
            oe_n = 1'b0;
        else
            ce_n = 1'b0;
        stp();
        {address_valid_strobe_n, ce_n, oe_n} = 3'h4;
        stp();
        stp();
        q = dq_out;
        idle();
    endtask
    // synchronous burst: ready seen in the nine cycles after the start edge
    task burst(input logic [21:0] a, output logic [8:0] rv, output logic [15:0] q);
        stp();
        {ce_n, oe_n, address_valid_strobe_n} = 3'h0;
        addr = a;
        stp();
        address_valid_strobe_n = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            rv[i] = rdy;
            q = dq_out;
            stp();
        end
        idle();
    endtask
endmodule // flash_host_model

// ### testbench/flash_seq_assertions.sv
// concurrent checks on the flash sequencer ports
`timescale 1ns/1ps
module flash_seq_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // host strobes and configuration
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic address_valid_strobe_n,
    input wire logic sync_read_mode,
    input wire logic ready_timing_select_bit,
    input wire logic [2:0] wait_states,
    // outputs and engine handshake
    input wire logic rdy,
    input wire logic [flash_cmd_pkg::DATA_W-1:0] dq_out,
    input wire logic [flash_cmd_pkg::DATA_W-1:0] array_rdata,
    input wire logic alg_start,
    input wire logic alg_done,
    input wire logic alg_suspend
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // burst start: strobe falls while selected and not writing
    sequence s_bst;
        clk_en && sync_read_mode && !ce_n && we_n && $fell(address_valid_strobe_n);
    endsequence
    property p_busy_rdy;
        clk_en && alg_start && !sync_read_mode |=> !rdy;
    endproperty
    a_busy_rdy: assert property (p_busy_rdy) else $error("ready high after start");
    // the cycle just after done may still read busy; a suspend also frees ready
    property p_busy_hold;
        clk_en && !rdy && !alg_done && !$past(alg_done) && !sync_read_mode
            |=> !rdy || sync_read_mode || alg_suspend;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("ready rose without done");
    property p_done_rdy;
        clk_en && alg_done && !alg_start && !sync_read_mode |-> ##[1:2] rdy;
    endproperty
    a_done_rdy: assert property (p_done_rdy) else $error("ready stuck low after done");
    property p_start_write;
        $rose(alg_start) |-> !$past(we_n, 2) || !$past(we_n, 3);
    endproperty
    a_start_write: assert property (p_start_write) else $error("start without write");
    property p_array;
        clk_en && !sync_read_mode && rdy && !alg_suspend && !alg_start && !oe_n && !ce_n
            |=> dq_out == $past(array_rdata);
    endproperty
    a_array: assert property (p_array) else $error("idle read not array data");
    property p_sync_idle;
        clk_en && sync_read_mode && ce_n ##1 clk_en && sync_read_mode && ce_n |-> rdy;
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("ready low outside burst");
    property p_lat0;
        s_bst ##0 !ready_timing_select_bit && wait_states == 3'h0 |=> !rdy ##1 rdy;
    endproperty
    a_lat0: assert property (p_lat0) else $error("ready not with first word");
    property p_lat1;
        s_bst ##0 ready_timing_select_bit && wait_states == 3'h2 |=> !rdy [*2] ##1 rdy;
    endproperty
    a_lat1: assert property (p_lat1) else $error("early ready misplaced");
endmodule // flash_seq_chk

bind flash_program_status_interface flash_seq_chk chk_u (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .address_valid_strobe_n(address_valid_strobe_n), .sync_read_mode(sync_read_mode),
    .ready_timing_select_bit(ready_timing_select_bit), .wait_states(wait_states),
    .rdy(rdy), .dq_out(dq_out), .array_rdata(array_rdata), .alg_start(alg_start),
    .alg_done(alg_done), .alg_suspend(alg_suspend));

// ### testbench/tb.sv
// self-checking bench for the flash program/status sequencer
`timescale 1ns/1ps
module tb;
    logic mclk, rst_n, clk_en, sync_read_mode, ready_timing_select_bit, alg_done;
    logic ce_n, oe_n, we_n, address_valid_strobe_n, dq_oe, rdy;
    logic alg_start, alg_erase, alg_chip, alg_suspend;
    logic [2:0] wait_states;
    logic [21:0] addr, array_addr, program_target_address;
    logic [15:0] dq_in, dq_out, array_rdata, program_word, s0, s1, s2;
    logic [8:0] rv;
    int mismatches = 0, checked = 0, cyc = 0, starts = 0;
    // array contents follow the low 16 address bits so every word in a 64K span is distinct
    assign array_rdata = array_addr[15:0] ^ 16'h5a5a;
    flash_program_status_interface dut_u (
        .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .address_valid_strobe_n(address_valid_strobe_n), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .rdy(rdy), .sync_read_mode(sync_read_mode),
        .ready_timing_select_bit(ready_timing_select_bit), .wait_states(wait_states),
        .array_addr(array_addr), .array_rdata(array_rdata), .alg_start(alg_start),
        .alg_erase(alg_erase), .alg_chip(alg_chip), .alg_suspend(alg_suspend),
        .program_target_address(program_target_address), .program_word(program_word),
        .alg_done(alg_done));
    flash_host_model host_u (
        .mclk(mclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .address_valid_strobe_n(address_valid_strobe_n), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .rdy(rdy));
    // clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // start pulses counted; the run is cut short if it hangs
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (alg_start === 1'b1)
            starts <= starts + 1;
        if (cyc == 3000)
        begin
            mismatches++;
            close_out();
        end
    end
    function automatic logic [15:0] aw(input logic [21:0] a);
        return a[15:0] ^ 16'h5a5a;
    endfunction
    task chk(input logic [21:0] got, input logic [21:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // unlock pair with junk in the upper address bits
    task unl();
        host_u.wr(22'h3a5555, 16'h00aa, 1'b0);
        host_u.wr(22'h1c52aa, 16'h0055, 1'b0);
    endtask
    task done();
        host_u.stp();
        alg_done = 1'b1;
        host_u.stp();
        alg_done = 1'b0;
        repeat (2) host_u.stp();
    endtask
    task t_async_prog();
        sync_read_mode = 1'b0;
        unl();
        host_u.wr(22'h000555, 16'h00a0, 1'b0);
        host_u.wr(22'h201234, 16'h00c3, 1'b0);
        repeat (2) host_u.stp();
        chk(starts, 1, "program not started");
        chk(program_target_address, 22'h201234, "program address");
        chk(program_word, 16'h00c3, "program word");
        chk(rdy, 1'b0, "ready while busy");
        host_u.rd(22'h201234, 1'b0, s0);
        host_u.rd(22'h201234, 1'b1, s1);
        chk(s0 & 16'hffbf, 16'h0000, "poll status word");
        chk(s0[6] ^ s1[6], 1'b1, "toggle by chip select");
        host_u.rd(22'h000100, 1'b0, s2);
        chk(s2, aw(22'h000100), "other bank read");
        done();
        chk(rdy, 1'b1, "ready after done");
        host_u.rd(22'h201234, 1'b0, s0);
        host_u.rd(22'h201234, 1'b1, s1);
        chk(s0, aw(22'h201234), "true data after done");
        chk(s1, s0, "toggle stopped");
        // a low clock enable must leave the last read word standing
        clk_en = 1'b0;
        host_u.rd(22'h000100, 1'b0, s2);
        clk_en = 1'b1;
        chk(s2, s1, "state moved while clock enable low");
    endtask
    task t_sync_prog();
        sync_read_mode = 1'b1;
        wait_states = 3'h2;
        unl();
        host_u.wr(22'h000555, 16'h00a0, 1'b0);
        host_u.wr(22'h105678, 16'h1234, 1'b1);
        repeat (2) host_u.stp();
        chk(starts, 2, "sync program not started");
        chk(program_target_address, 22'h105678, "first event address");
        host_u.burst(22'h105678, rv, s0);
        chk(rv, 9'b111111000, "status burst ready");
        chk(s0 & 16'hffbf, 16'h0080, "status burst word");
        done();
    endtask
    task t_erase();
        sync_read_mode = 1'b0;
        unl();
        host_u.wr(22'h000555, 16'h0080, 1'b0);
        unl();
        host_u.wr(22'h308000, 16'h0030, 1'b0);
        repeat (2) host_u.stp();
        chk(alg_erase, 1'b1, "erase flag");
        chk(program_target_address[21:15], 7'h61, "erase sector");
        host_u.rd(22'h308010, 1'b0, s0);
        chk(s0 & 16'hffbb, 16'h0008, "erase status");
        host_u.wr(22'h000000, 16'h00b0, 1'b0);
        repeat (2) host_u.stp();
        chk(alg_suspend, 1'b1, "suspend flag");
        host_u.rd(22'h308010, 1'b1, s1);
        chk(s1[7], 1'b1, "suspended poll bit");
        host_u.rd(22'h310020, 1'b0, s0);
        chk(s0, aw(22'h310020), "other sector data");
        host_u.rd(22'h308010, 1'b0, s2);
        chk(s1[2] ^ s2[2], 1'b1, "suspend toggle count");
        host_u.rd(22'h310020, 1'b1, s0);
        chk(s0, aw(22'h310020), "other sector data by chip select");
        host_u.rd(22'h308010, 1'b1, s1);
        chk(s1[2] ^ s2[2], 1'b1, "suspend toggle by chip select");
        host_u.wr(22'h000000, 16'h0030, 1'b0);
        host_u.stp();
        chk(alg_suspend, 1'b0, "resume");
        done();
        // chip erase ends on the unlock address with its own code
        unl();
        host_u.wr(22'h000555, 16'h0080, 1'b0);
        unl();
        host_u.wr(22'h000555, 16'h0010, 1'b0);
        repeat (2) host_u.stp();
        chk(alg_chip, 1'b1, "chip erase flag");
        done();
    endtask
    // latency pattern and last word for one burst setting
    task bt(input logic sel, input logic [2:0] ws, input logic [21:0] a, input logic [8:0] er,
        input logic [21:0] ea);
        ready_timing_select_bit = sel;
        wait_states = ws;
        host_u.burst(a, rv, s0);
        chk(dq_oe, 1'b1, "output enable after burst");
        chk(rv, er, "ready pattern");
        chk(s0, aw(ea), "burst word");
    endtask
    initial
    begin
        {clk_en, sync_read_mode, ready_timing_select_bit, alg_done, rst_n} = 5'h10;
        wait_states = 3'h0;
        repeat (4) @(posedge mclk);
        #5;
        rst_n = 1'b1;
        chk(rdy, 1'b1, "ready after reset");
        chk(dq_oe, 1'b0, "output enable after reset");
        chk(alg_start, 1'b0, "start after reset");
        t_async_prog();
        t_sync_prog();
        t_erase();
        sync_read_mode = 1'b1;
        bt(1'b0, 3'h0, 22'h10003c, 9'b110011110, 22'h100041);
        bt(1'b1, 3'h0, 22'h10003c, 9'b111001111, 22'h100041);
        bt(1'b0, 3'h0, 22'h10003e, 9'b111111110, 22'h100045);
        bt(1'b1, 3'h2, 22'h100010, 9'b111111100, 22'h100015);
        close_out();
    end
endmodule // tb
